// file: src/ulpis_pkg.sv
// Package: register map, reset values and carrier types of the interrupt status block
package ulpis_pkg;

	// ==========================================================
	// Register read and write addresses
	localparam logic [5:0] ADDR_RISE_WR = 6'h0D;
	localparam logic [5:0] ADDR_RISE_SET = 6'h0E;
	localparam logic [5:0] ADDR_RISE_CLR = 6'h0F;
	localparam logic [5:0] ADDR_FALL_WR = 6'h10;
	localparam logic [5:0] ADDR_FALL_SET = 6'h11;
	localparam logic [5:0] ADDR_FALL_CLR = 6'h12;
	localparam logic [5:0] ADDR_SRC_STATUS = 6'h13;
	localparam logic [5:0] ADDR_EVENT_LATCH = 6'h14;
	localparam logic [5:0] ADDR_LINE_DEBUG = 6'h15;
	localparam logic [5:0] ADDR_SCRATCH_WR = 6'h16;
	localparam logic [5:0] ADDR_SCRATCH_SET = 6'h17;
	localparam logic [5:0] ADDR_SCRATCH_CLR = 6'h18;

	// ==========================================================
	// Field positions and widths
	localparam int NUM_SRC = 5;
	localparam int LINE_W = 2;
	localparam int POS_ID_PIN_GROUNDED = 4;
	localparam int POS_SESSION_ENDED = 3;
	localparam int POS_SESSION_IS_VALID = 2;
	localparam int POS_BUS_POWER_VALID = 1;
	localparam int POS_HOST_DISC = 0;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_MASK = 8'h1F;
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [7:0] RST_SCRATCH = 8'h00;
	localparam logic [NUM_SRC-1:0] RST_SRC = 5'h00;
	localparam logic [LINE_W-1:0] RST_LINE = 2'h0;

	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic rd;
		logic wr;
		logic [5:0] addr;
		logic [7:0] wdata;
	} ulpis_reg_req_s;

	typedef struct packed {
		logic id_pin_grounded;
		logic session_ended;
		logic session_is_valid;
		logic bus_power_valid;
		logic host_disconnect_seen;
	} ulpis_src_s;

endpackage : ulpis_pkg

// file: src/ulpis_intr_latch.sv
// Interrupt source status, event latch, line-state debug and scratch registers of a ULPI transceiver
//
// Behaviour
// - Status register 13h bit 4 shows live ID ground; bits 7-5 reserved.
// - Status bits 3..0 track session end, session valid, Bus_power_valid, host disconnect.
// - Latch register 14h bits 4..0 set on unmasked transition of matching source.
// - Reading the latch register returns latched bits then clears them, except bits set by an event in that same cycle.
// - Entering low-power mode clears every latch bit not set by an event in that same cycle.
// - While clock runs, unmasked source changes go to link as receive-command events.
// - Debug register 15h shows live two-bit line state; upper bits zero.
// - Eight-bit scratch byte resets to 00h and affects nothing else.
// - Scratch readable 16h-18h; written 16h, bit-set 17h, bit-cleared 18h.
// - Rising transition unmasked only when rise enable bit at 0Dh set.
// - Falling transition unmasked only when fall enable bit at 10h set.
module ulpis_intr_latch (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire ulpis_pkg::ulpis_src_s src_pins,
	input wire logic line_state_bit0,
	input wire logic line_state_bit1,
	input wire logic low_power_enter,
	input wire ulpis_pkg::ulpis_reg_req_s reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	output logic rxcmd_req,
	output logic [4:0] rxcmd_src
);

	localparam int NIN = ulpis_pkg::NUM_SRC + ulpis_pkg::LINE_W;

	// ==========================================================
	// Input synchronisers
	// Three stages; a change is taken only once stages two and three agree,
	// which filters a single-cycle glitch at the cost of one more cycle of latency.
	logic [NIN-1:0] raw_in;
	logic [NIN-1:0] filt_q;
	logic [NIN-1:0] filt_d;
	assign raw_in = {line_state_bit1, line_state_bit0, src_pins};

	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++) begin : g_sync
			logic s1_q;
			logic s2_q;
			logic s3_q;
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
				end else if (ce) begin
					s1_q <= raw_in[gi];
					s2_q <= s1_q;
					s3_q <= s2_q;
				end
			end
			assign filt_d[gi] = (s2_q == s3_q) ? s3_q : filt_q[gi];
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			filt_q <= {ulpis_pkg::RST_LINE, ulpis_pkg::RST_SRC};
		end else if (ce) begin
			filt_q <= filt_d;
		end
	end

	// ==========================================================
	// Live status and edge detection
	logic [4:0] src_now;
	logic [4:0] src_next;
	logic [4:0] rise_ev;
	logic [4:0] fall_ev;
	logic [4:0] hit_ev;
	logic [7:0] rise_mask_q;
	logic [7:0] fall_mask_q;
	assign src_now = filt_q[4:0];
	assign src_next = filt_d[4:0];
	assign rise_ev = src_next & ~src_now;
	assign fall_ev = src_now & ~src_next;
	assign hit_ev = (rise_ev & rise_mask_q[4:0]) | (fall_ev & fall_mask_q[4:0]);

	// ==========================================================
	// Register access decode
	logic wr;
	logic rd;
	logic [5:0] addr;
	logic [7:0] wdata;
	assign wr = reg_req.wr;
	assign rd = reg_req.rd;
	assign addr = reg_req.addr;
	assign wdata = reg_req.wdata;

	function automatic logic [7:0] wsc(input logic [7:0] cur, input logic [5:0] a, input logic [5:0] base,
		input logic w, input logic [7:0] d);
		logic [7:0] r;
		r = cur;
		if (w && a == base) begin
			r = d;
		end else if (w && a == base + 6'h01) begin
			r = cur | d;
		end else if (w && a == base + 6'h02) begin
			r = cur & ~d;
		end
		return r;
	endfunction : wsc

	logic [7:0] scratch_q;
	logic [7:0] rise_mask_d;
	logic [7:0] fall_mask_d;
	logic [7:0] scratch_d;
	assign rise_mask_d = wsc(rise_mask_q, addr, ulpis_pkg::ADDR_RISE_WR, wr, wdata);
	assign fall_mask_d = wsc(fall_mask_q, addr, ulpis_pkg::ADDR_FALL_WR, wr, wdata);
	assign scratch_d = wsc(scratch_q, addr, ulpis_pkg::ADDR_SCRATCH_WR, wr, wdata);

	// ==========================================================
	// Event latch
	logic [4:0] latch_q;
	logic [4:0] latch_d;
	logic latch_rd;
	assign latch_rd = rd && (addr == ulpis_pkg::ADDR_EVENT_LATCH);
	// clear on low power
	// A new event in the clearing cycle survives: set wins over clear.
	assign latch_d = ((latch_rd || low_power_enter) ? 5'h00 : latch_q) | hit_ev;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			latch_q <= ulpis_pkg::RST_LATCH[4:0];
			rise_mask_q <= ulpis_pkg::RST_MASK;
			fall_mask_q <= ulpis_pkg::RST_MASK;
			scratch_q <= ulpis_pkg::RST_SCRATCH;
		end else if (ce) begin
			latch_q <= latch_d;
			rise_mask_q <= rise_mask_d;
			fall_mask_q <= fall_mask_d;
			scratch_q <= scratch_d;
		end
	end

	// ==========================================================
	// Read data mux
	logic [7:0] rd_mux;
	logic in_rise;
	logic in_fall;
	logic in_scr;
	assign in_rise = addr >= ulpis_pkg::ADDR_RISE_WR && addr <= ulpis_pkg::ADDR_RISE_CLR;
	assign in_fall = addr >= ulpis_pkg::ADDR_FALL_WR && addr <= ulpis_pkg::ADDR_FALL_CLR;
	assign in_scr = addr >= ulpis_pkg::ADDR_SCRATCH_WR && addr <= ulpis_pkg::ADDR_SCRATCH_CLR;

	always_comb begin
		rd_mux = 8'h00;
		if (in_rise) begin
			rd_mux = rise_mask_q;
		end else if (in_fall) begin
			rd_mux = fall_mask_q;
		end else if (addr == ulpis_pkg::ADDR_SRC_STATUS) begin
			rd_mux = {3'h0, src_now};
		end else if (addr == ulpis_pkg::ADDR_EVENT_LATCH) begin
			rd_mux = {3'h0, latch_q};
		end else if (addr == ulpis_pkg::ADDR_LINE_DEBUG) begin
			rd_mux = {6'h00, filt_q[NIN-1:ulpis_pkg::NUM_SRC]};
		end else if (in_scr) begin
			rd_mux = scratch_q;
		end
	end

	// ==========================================================
	// Outputs
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
			rxcmd_req <= 1'b0;
			rxcmd_src <= ulpis_pkg::RST_SRC;
		end else if (ce) begin
			reg_rdata <= rd ? rd_mux : reg_rdata;
			reg_rvalid <= rd;
			rxcmd_req <= |hit_ev;
			rxcmd_src <= src_next;
		end
	end

endmodule : ulpis_intr_latch

// file: sim/ulpis_intr_props.sv
// Checker: port-level assertions of the interrupt status block
module ulpis_intr_props (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire ulpis_pkg::ulpis_src_s src_pins,
	input wire logic line_state_bit0,
	input wire logic line_state_bit1,
	input wire logic low_power_enter,
	input wire ulpis_pkg::ulpis_reg_req_s reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic rxcmd_req,
	input wire logic [4:0] rxcmd_src
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	wire rd = ce && reg_req.rd;
	wire [5:0] a = reg_req.addr;
	// ==========================================================
	// Register answers
	rv_pulse_a: assert property (rd |=> reg_rvalid) else $error("read not answered");
	hold_data_a: assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("read data moved");
	stat_live_a: assert property (rd && a == 6'h13 |=> reg_rdata == {3'h0, $past(rxcmd_src)})
		else $error("status mismatch");
	dbg_line_a: assert property (rd && a == 6'h15 |=> reg_rdata == {6'h00, $past(line_state_bit1), $past(line_state_bit0)})
		else $error("line state mismatch");
	unmap_zero_a: assert property (rd && a == 6'h3F |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	scr_back_a: assert property (ce && reg_req.wr && a == 6'h16 ##1 (rd && a == 6'h16 && !reg_req.wr)
		|=> reg_rdata == $past(reg_req.wdata, 2)) else $error("scratch readback wrong");
	// ==========================================================
	// Latch clearing and events; clears are checked only where no event races the clear
	lat_clr_a: assert property (rd && a == 6'h14 ##1 !rxcmd_req ##1 (rd && a == 6'h14 && !rxcmd_req)
		|=> reg_rdata == 8'h00)
		else $error("latch not cleared by read");
	lp_clr_a: assert property (ce && low_power_enter ##1 (rd && a == 6'h14 && !rxcmd_req) |=> reg_rdata == 8'h00)
		else $error("latch not cleared by low power");
	evt_change_a: assert property ($past(ce) && rxcmd_req |-> rxcmd_src != $past(rxcmd_src))
		else $error("event without source change");
endmodule : ulpis_intr_props
bind ulpis_intr_latch ulpis_intr_props u_props (.ref_clk, .nrst, .ce, .src_pins, .line_state_bit0, .line_state_bit1,
	.low_power_enter, .reg_req, .reg_rdata, .reg_rvalid, .rxcmd_req, .rxcmd_src);

// file: sim/ulpis_link_model.sv
// Link controller model: register strobes toward the block and event counting
module ulpis_link_model (
	input wire logic ref_clk,
	input wire logic [7:0] reg_rdata,
	input wire logic rxcmd_req,
	output ulpis_pkg::ulpis_reg_req_s reg_req
);
	timeunit 1ns;
	timeprecision 1ns;
	int evt_cnt = 0;
	initial reg_req = '0;
	// events via rxcmd, so latch reads stay optional
	always @(posedge ref_clk) begin
		if (rxcmd_req) evt_cnt <= evt_cnt + 1;
	end
	// Write is left standing so a following read lands back to back; repeats are harmless
	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		@(negedge ref_clk);
		reg_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(input logic [5:0] a, output logic [7:0] v);
		@(negedge ref_clk);
		reg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		// One edge only: a second edge would be a second read and clear the latch
		@(negedge ref_clk);
		v = reg_rdata;
		reg_req <= '0;
	endtask : rd
endmodule : ulpis_link_model

// file: sim/ulpis_intr_latch_test.sv
// Testbench: register table rows, then event latch scenarios
`define CHK(g, e) total_checks++; if ((g) !== (e)) begin error_cnt++; $display("BAD t=%0t got %h exp %h", $time, g, e); end
module ulpis_intr_latch_test;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic w; logic [5:0] a; logic [7:0] v;} ulpis_row_s;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic lp = 1'b0;
	ulpis_pkg::ulpis_src_s src = '0;
	ulpis_pkg::ulpis_reg_req_s reg_req;
	logic [7:0] rdata;
	logic rvalid, rxq;
	logic [4:0] rxs;
	logic [7:0] d;
	int error_cnt = 0;
	int total_checks = 0;
	int e0;
	ulpis_row_s rows[12] = '{'{1'b0, 6'h14, 8'h00}, '{1'b0, 6'h16, 8'h00}, '{1'b1, 6'h16, 8'hA5}, '{1'b0, 6'h16, 8'hA5},
		'{1'b1, 6'h17, 8'h0A}, '{1'b0, 6'h17, 8'hAF}, '{1'b1, 6'h18, 8'h21}, '{1'b0, 6'h18, 8'h8E},
		'{1'b1, 6'h13, 8'hFF}, '{1'b0, 6'h13, 8'h00}, '{1'b0, 6'h15, 8'h02}, '{1'b0, 6'h3F, 8'h00}};
	always #10 ref_clk = ~ref_clk;
	ulpis_link_model link (.ref_clk(ref_clk), .reg_rdata(rdata), .rxcmd_req(rxq), .reg_req(reg_req));
	ulpis_intr_latch dut (.ref_clk(ref_clk), .nrst(nrst), .ce(1'b1), .src_pins(src), .line_state_bit0(1'b0),
		.line_state_bit1(1'b1), .low_power_enter(lp), .reg_req(reg_req), .reg_rdata(rdata), .reg_rvalid(rvalid),
		.rxcmd_req(rxq), .rxcmd_src(rxs));
	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report
	// Filtered status and latch need four edges; six cycles leaves margin
	task automatic settle_read(input logic [5:0] a, output logic [7:0] v);
		repeat (6) @(negedge ref_clk);
		link.rd(a, v);
	endtask : settle_read
	initial begin
		repeat (2) @(negedge ref_clk);
		nrst = 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w) link.wr(rows[i].a, rows[i].v);
			else begin
				link.rd(rows[i].a, d);
				`CHK(d, rows[i].v)
			end
		end
		e0 = link.evt_cnt;
		src.id_pin_grounded = 1'b1;
		settle_read(6'h13, d);
		`CHK(d, 8'h10)
		link.rd(6'h14, d);
		`CHK(d, 8'h10)
		`CHK(link.evt_cnt, e0 + 1)
		link.rd(6'h14, d);
		`CHK(d, 8'h00)
		link.wr(6'h0D, 8'h00);
		src.session_ended = 1'b1;
		settle_read(6'h14, d);
		`CHK(d, 8'h00)
		link.rd(6'h13, d);
		`CHK(d, 8'h18)
		src.session_ended = 1'b0;
		settle_read(6'h14, d);
		`CHK(d, 8'h08)
		src.id_pin_grounded = 1'b0;
		repeat (6) @(negedge ref_clk);
		lp = 1'b1;
		fork
			link.rd(6'h14, d);
			begin
				@(negedge ref_clk);
				lp = 1'b0;
			end
		join
		`CHK(d, 8'h00)
		final_report();
	end
	initial begin
		#100us;
		error_cnt++;
		final_report();
	end
endmodule : ulpis_intr_latch_test
